// >>> verilog/fcct_pkg.sv
// Purpose: Shared constants and carriers for the cycle timing sequencer
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes: Added control register sits outside the classic map

package fcct_pkg;

    // ************************************************************
    // Clock and machine cycle
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLKS_PER_MCYCLE = 4;
    localparam int TMR_SLOW_CLKS = 12;
    localparam int TMR_FAST_CLKS = 4;
    localparam logic [3:0] TMR_SLOW_LAST = 4'(TMR_SLOW_CLKS - 1);
    localparam logic [3:0] TMR_FAST_LAST = 4'(TMR_FAST_CLKS - 1);

    // ************************************************************
    // Instruction cycle limits
    // ************************************************************
    localparam logic [3:0] MIN_CYCLES = 4'h1;
    localparam logic [3:0] MAX_CYCLES = 4'h5;
    localparam logic [3:0] XMOVE_BASE_CYCLES = 4'h2;

    // ************************************************************
    // Added control register (timing control)
    // ************************************************************
    localparam logic [7:0] TCTL_ADDR = 8'h8E;
    localparam int TCTL_STRETCH_LSB = 0;
    localparam int TCTL_STRETCH_W = 3;
    localparam int TCTL_TFAST_BIT = 3;
    localparam logic [7:0] TCTL_RESET = 8'h01;
    localparam logic [7:0] TCTL_WMASK = 8'h0F;

    // ************************************************************
    // Phase codes, one-hot
    // ************************************************************
    localparam logic [3:0] PH0 = 4'h1;
    localparam logic [3:0] PH3 = 4'h8;

    // Sequencer states
    typedef enum logic [1:0] {
        FCCT_IDLE = 2'h1,
        FCCT_RUN = 2'h2
    } fcct_state_t;

    // Instruction descriptor from the decoder
    typedef struct packed {
        logic valid;
        logic [1:0] bytes;
        logic [1:0] extra;
        logic xmove;
        logic uses_ri;
        logic ri_sel;
    } fcct_instr_t;

    // Internal special register write port
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } fcct_sfr_wr_t;

endpackage

// >>> verilog/fcct_phase_gen.sv
// Purpose: Four-phase machine cycle counter with latch strobe
// Assumes: Runs on every clock, synchronous active-low reset
// Notes: Strobe is high for all of phase 0

`timescale 1ns/1ps

module fcct_phase_gen (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Phase outputs
    output logic [3:0] phase_o,
    output logic cycle_end_o,
    output logic ale_o
);

    logic [3:0] phase_q;
    logic [3:0] phase_d;
    logic ale_q;

    // Rotate one-hot phase, wrap every four clocks
    assign phase_d = {phase_q[2:0], phase_q[3]};
    assign phase_o = phase_q;
    assign cycle_end_o = (phase_q == fcct_pkg::PH3);
    assign ale_o = ale_q;

    // Reset parks in phase 3 so the first cycle opens cleanly
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            phase_q <= fcct_pkg::PH3;
            ale_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            ale_q <= (phase_d == fcct_pkg::PH0);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_phase_one_hot: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $onehot(phase_q))
        else $error("phase counter not one-hot");

    chk_ale_period: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(ale_q) |-> ##1 !ale_q [*3] ##1 ale_q)
        else $error("latch strobe not once per four clocks");

endmodule

// >>> verilog/fcct_core_timing.sv
// Contract
// - Machine cycle lasts exactly four clocks
// - Timers tick every twelve clocks after reset
// - Software may select four-clock timer tick
// - One latch strobe per machine cycle
// - Fastest external data move takes two cycles
// - Three-byte direct move takes three cycles
// - Usually one machine cycle per instruction byte
// - Instructions last one to five cycles; external moves take two plus stretch, up to nine
// - Results and flags match classic core
// - Indirect operand uses register zero or one
// - Added controls avoid classic register addresses
//
// Purpose: Machine cycle and instruction timing sequencer
// Assumes: Decoder supplies byte count and extra cycles per opcode
// Notes: Data results are untouched here; only timing and operand addresses are produced

`timescale 1ns/1ps

module fcct_core_timing (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Instruction descriptor and operand sources
    input wire fcct_pkg::fcct_instr_t instr_i,
    input wire logic [7:0] r0_i,
    input wire logic [7:0] r1_i,
    input wire logic [7:0] p2_latch_i,
    // Internal special register writes
    input wire fcct_pkg::fcct_sfr_wr_t sfr_wr_i,
    // Cycle outputs
    output logic ale_o,
    output logic mcycle_end_o,
    // Instruction status
    output logic busy_o,
    output logic instr_taken_o,
    output logic instr_done_o,
    output logic [3:0] cycles_o,
    // Operand addresses
    output logic ind_valid_o,
    output logic [7:0] ind_addr_o,
    output logic ext_valid_o,
    output logic [15:0] ext_addr_o,
    // Timer side
    output logic timer_tick_o,
    output logic [7:0] tctl_o
);

    // ************************************************************
    // Helpers
    // ************************************************************

    // Cycle count: one per byte plus extras, clamped to 1..5; external moves take 2 plus stretch, unclamped
    function automatic logic [3:0] calc_cycles(
        input fcct_pkg::fcct_instr_t ins,
        input logic [2:0] stretch
    );
        logic [3:0] sum;
        sum = 4'({2'h0, ins.bytes}) + 4'({2'h0, ins.extra});
        if (ins.xmove) begin
            calc_cycles = fcct_pkg::XMOVE_BASE_CYCLES + 4'({1'b0, stretch});
        end else if (sum < fcct_pkg::MIN_CYCLES) begin
            calc_cycles = fcct_pkg::MIN_CYCLES;
        end else if (sum > fcct_pkg::MAX_CYCLES) begin
            calc_cycles = fcct_pkg::MAX_CYCLES;
        end else begin
            calc_cycles = sum;
        end
    endfunction

    // Classic register map, which the added control must never use
    function automatic logic is_classic_sfr(input logic [7:0] a);
        case (a)
            8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8A,
            8'h8B, 8'h8C, 8'h8D, 8'h90, 8'h98, 8'h99, 8'hA0, 8'hA8,
            8'hB0, 8'hB8, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD0,
            8'hE0, 8'hF0: is_classic_sfr = 1'b1;
            default: is_classic_sfr = 1'b0;
        endcase
    endfunction

    // ************************************************************
    // Phase generator
    // ************************************************************
    logic [3:0] phase;
    logic cycle_end;
    logic ale_w;

    fcct_phase_gen u_phase (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .phase_o(phase),
        .cycle_end_o(cycle_end),
        .ale_o(ale_w)
    );

    // ************************************************************
    // Timing control register
    // ************************************************************
    logic [7:0] tctl_q;
    logic [7:0] tctl_d;
    logic tctl_hit;
    logic [2:0] stretch;
    logic tfast;

    // Decode only the added address; classic addresses never land here
    assign tctl_hit = sfr_wr_i.we && (sfr_wr_i.addr == fcct_pkg::TCTL_ADDR)
        && !is_classic_sfr(sfr_wr_i.addr);
    assign tctl_d = tctl_hit ? (sfr_wr_i.data & fcct_pkg::TCTL_WMASK)
        : tctl_q;
    assign stretch = tctl_q[fcct_pkg::TCTL_STRETCH_LSB +:
        fcct_pkg::TCTL_STRETCH_W];
    assign tfast = tctl_q[fcct_pkg::TCTL_TFAST_BIT];

    // Reset value keeps the slow timer rate
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tctl_q <= fcct_pkg::TCTL_RESET;
        end else begin
            tctl_q <= tctl_d;
        end
    end

    // ************************************************************
    // Timer prescaler
    // ************************************************************
    logic [3:0] pre_q;
    logic [3:0] pre_last;
    logic pre_wrap;
    logic tick_q;

    // Rate change takes effect at the next wrap or overshoot
    assign pre_last = tfast ? fcct_pkg::TMR_FAST_LAST
        : fcct_pkg::TMR_SLOW_LAST;
    assign pre_wrap = (pre_q >= pre_last);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pre_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_wrap ? 4'h0 : pre_q + 4'h1;
            tick_q <= pre_wrap;
        end
    end

    // ************************************************************
    // Instruction sequencer
    // ************************************************************
    fcct_pkg::fcct_state_t state_q;
    fcct_pkg::fcct_state_t state_d;
    logic [3:0] remain_q;
    logic [3:0] remain_d;
    logic [3:0] new_cycles;
    logic can_take;
    logic take;
    logic last_cycle;
    logic done_d;

    // Next instruction may start in the cycle after the last one
    assign last_cycle = (state_q == fcct_pkg::FCCT_RUN)
        && (remain_q == 4'h1);
    assign can_take = (state_q == fcct_pkg::FCCT_IDLE) || last_cycle;
    assign take = cycle_end && instr_i.valid && can_take;
    assign new_cycles = calc_cycles(instr_i, stretch);
    assign done_d = cycle_end && last_cycle;

    // Cycle counting only; operands and flags pass untouched
    always_comb begin
        state_d = state_q;
        remain_d = remain_q;
        case (state_q)
            fcct_pkg::FCCT_IDLE: begin
                if (take) begin
                    state_d = fcct_pkg::FCCT_RUN;
                    remain_d = new_cycles;
                end
            end
            fcct_pkg::FCCT_RUN: begin
                if (take) begin
                    remain_d = new_cycles;
                end else if (done_d) begin
                    state_d = fcct_pkg::FCCT_IDLE;
                    remain_d = 4'h0;
                end else if (cycle_end) begin
                    remain_d = remain_q - 4'h1;
                end
            end
            default: begin
                state_d = fcct_pkg::FCCT_IDLE;
                remain_d = 4'h0;
            end
        endcase
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    logic busy_q;
    logic taken_q;
    logic done_q;
    logic mend_q;
    logic [3:0] cycles_q;
    logic ind_valid_q;
    logic [7:0] ind_addr_q;
    logic ext_valid_q;
    logic [15:0] ext_addr_q;
    logic [7:0] ri_val;

    assign ri_val = instr_i.ri_sel ? r1_i : r0_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_q <= fcct_pkg::FCCT_IDLE;
            remain_q <= 4'h0;
            busy_q <= 1'b0;
            taken_q <= 1'b0;
            done_q <= 1'b0;
            mend_q <= 1'b0;
            cycles_q <= 4'h0;
        end else begin
            state_q <= state_d;
            remain_q <= remain_d;
            busy_q <= (state_d == fcct_pkg::FCCT_RUN);
            taken_q <= take;
            done_q <= done_d;
            mend_q <= cycle_end;
            if (take) begin
                cycles_q <= new_cycles;
            end
        end
    end

    // External moves address through the port 2 latch, not internal RAM
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ind_valid_q <= 1'b0;
            ind_addr_q <= 8'h00;
            ext_valid_q <= 1'b0;
            ext_addr_q <= 16'h0000;
        end else if (take) begin
            ind_valid_q <= instr_i.uses_ri && !instr_i.xmove;
            ind_addr_q <= ri_val;
            ext_valid_q <= instr_i.uses_ri && instr_i.xmove;
            ext_addr_q <= {p2_latch_i, ri_val};
        end
    end

    assign ale_o = ale_w;
    assign mcycle_end_o = mend_q;
    assign busy_o = busy_q;
    assign instr_taken_o = taken_q;
    assign instr_done_o = done_q;
    assign cycles_o = cycles_q;
    assign ind_valid_o = ind_valid_q;
    assign ind_addr_o = ind_addr_q;
    assign ext_valid_o = ext_valid_q;
    assign ext_addr_o = ext_addr_q;
    assign timer_tick_o = tick_q;
    assign tctl_o = tctl_q;

    // ************************************************************
    // Checks
    // ************************************************************
    logic [3:0] tgap_q;

    // Clocks since the last timer tick, for rate checks
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tgap_q <= 4'h0;
        end else begin
            tgap_q <= tick_q ? 4'h1 : tgap_q + 4'h1;
        end
    end

    chk_timer_slow_rate: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (tick_q && !tfast && $stable(tctl_q) && tgap_q != 4'h0
            && $past(tick_q, 12)) |-> tgap_q == 4'hC)
        else $error("slow timer tick not every twelve clocks");

    chk_timer_fast_rate: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (tick_q && tfast && $stable(tctl_q) && $past(tfast, 4))
            |-> ##4 tick_q)
        else $error("fast timer tick not every four clocks");

    chk_xmove_two_cycles: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (take && instr_i.xmove && stretch == 3'h0)
            |-> ##2 !done_q [*7] ##1 done_q)
        else $error("fast external move not eight clocks");

    chk_direct_move_three: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (take && !instr_i.xmove && instr_i.bytes == 2'h3
            && instr_i.extra == 2'h0) |-> ##13 done_q)
        else $error("three-byte move not twelve clocks");

    chk_cycle_range: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (taken_q && !ext_valid_q) |-> (cycles_q >= fcct_pkg::MIN_CYCLES
            && (cycles_q <= fcct_pkg::MAX_CYCLES || $past(instr_i.xmove))))
        else $error("instruction length outside one to five cycles");

    chk_ind_select: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (take && instr_i.uses_ri && !instr_i.xmove) |=> ind_valid_q
            && ind_addr_q == ($past(instr_i.ri_sel) ? $past(r1_i)
            : $past(r0_i)) && !ext_valid_q)
        else $error("indirect operand address wrong");

    chk_classic_untouched: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (sfr_wr_i.we && is_classic_sfr(sfr_wr_i.addr)) |=> $stable(tctl_q))
        else $error("classic address changed timing control");

    chk_done_on_strobe: assert property (
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        done_q |-> ale_w && mend_q)
        else $error("completion off machine cycle boundary");

endmodule

// >>> bench/fcct_ext_mem.sv
// Purpose: External data memory address latch seen from the bus side
// Assumes: Address is offered on the latch strobe of each machine cycle
// Notes: Holds only the last external data address it latched

`timescale 1ns/1ps

module fcct_ext_mem (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Bus side of the core
    input wire logic ale_i,
    input wire logic ext_valid_i,
    input wire logic [15:0] ext_addr_i,
    // Observation
    output logic [15:0] last_addr_o
);
    // ************************************************************
    // Address latch
    // ************************************************************
    // Latch only on the strobe, as a real address latch would
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            last_addr_o <= 16'h0000;
        end else if (ale_i && ext_valid_i) begin
            last_addr_o <= ext_addr_i;
        end
    end
endmodule

// >>> bench/fcct_core_timing_tb.sv
// Purpose: Self-checking bench for the cycle timing sequencer
// Assumes: Inputs change on the falling edge, outputs read there too
// Notes: Durations are measured from the taken pulse to the done pulse

`timescale 1ns/1ps

module fcct_core_timing_tb;
    // ************************************************************
    // Stimulus and observation
    // ************************************************************
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    fcct_pkg::fcct_instr_t instr_i = '0;
    logic [7:0] r0_i = 8'h00;
    logic [7:0] r1_i = 8'h00;
    logic [7:0] p2_latch_i = 8'h00;
    fcct_pkg::fcct_sfr_wr_t sfr_wr_i = '0;
    logic ale_o, mcycle_end_o, busy_o, instr_taken_o, instr_done_o;
    logic [3:0] cycles_o;
    logic ind_valid_o, ext_valid_o, timer_tick_o;
    logic [7:0] ind_addr_o, tctl_o;
    logic [15:0] ext_addr_o, mem_addr;
    logic [1:0] sig;
    int cyc = 0;
    int num_errors = 0;
    int total_checks = 0;

    assign sig = {timer_tick_o, ale_o};

    fcct_core_timing dut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
        .r0_i(r0_i), .r1_i(r1_i), .p2_latch_i(p2_latch_i),
        .sfr_wr_i(sfr_wr_i), .ale_o(ale_o), .mcycle_end_o(mcycle_end_o),
        .busy_o(busy_o), .instr_taken_o(instr_taken_o),
        .instr_done_o(instr_done_o), .cycles_o(cycles_o),
        .ind_valid_o(ind_valid_o), .ind_addr_o(ind_addr_o),
        .ext_valid_o(ext_valid_o), .ext_addr_o(ext_addr_o),
        .timer_tick_o(timer_tick_o), .tctl_o(tctl_o)
    );

    fcct_ext_mem mem (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ale_i(ale_o),
        .ext_valid_i(ext_valid_o), .ext_addr_i(ext_addr_o),
        .last_addr_o(mem_addr)
    );

    // Clock, cycle count and hang guard; tests need about 200 cycles
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // Clock counts are bench integers, never design values
    task automatic chk_cnt(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic wait_rise(input int w);
        int i;
        i = 0;
        @(negedge sys_clk_i);
        while (sig[w] !== 1'b1 && i < 40) begin
            @(negedge sys_clk_i);
            i++;
        end
    endtask

    // Skips the first pulse so a rate switch has settled
    task automatic period(input int w, output int p);
        int t0;
        wait_rise(w);
        wait_rise(w);
        t0 = cyc;
        wait_rise(w);
        p = cyc - t0;
    endtask

    // Valid is held until the taken pulse, as the port requires
    task automatic run_instr(input fcct_pkg::fcct_instr_t ins,
                             output int clks);
        int t0;
        int i;
        @(negedge sys_clk_i);
        instr_i = ins;
        i = 0;
        while (instr_taken_o !== 1'b1 && i < 50) begin
            @(negedge sys_clk_i);
            i++;
        end
        t0 = cyc;
        instr_i = '0;
        i = 0;
        while (instr_done_o !== 1'b1 && i < 100) begin
            @(negedge sys_clk_i);
            i++;
        end
        clks = cyc - t0;
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        sfr_wr_i = '{we: 1'b1, addr: a, data: d};
        @(negedge sys_clk_i);
        sfr_wr_i = '0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic test_reset();
        repeat (8) @(negedge sys_clk_i);
        chk_val(16'(tctl_o), 16'h0001);
        chk_val(16'({ale_o, busy_o, timer_tick_o}), 16'h0000);
        rst_b_i = 1'b1;
        @(negedge sys_clk_i);
        chk_val(16'(ale_o), 16'h0001);
    endtask

    // One strobe per four clocks, cycle end on the same clock
    task automatic test_phase();
        int highs;
        highs = 0;
        repeat (16) begin
            @(negedge sys_clk_i);
            highs += int'(ale_o === 1'b1);
            chk_val(16'(mcycle_end_o), 16'(ale_o));
        end
        chk_cnt(highs, 4);
    endtask

    task automatic test_timer(input int exp);
        int p;
        period(1, p);
        chk_cnt(p, exp);
    endtask

    // Byte and extra cycle combinations up to and one past the clamp
    task automatic test_cycles();
        int bt[5] = '{1, 2, 3, 3, 3};
        int ex[5] = '{0, 0, 0, 2, 3};
        int nc[5] = '{1, 2, 3, 5, 5};
        int clks;
        fcct_pkg::fcct_instr_t ins;
        for (int k = 0; k < 5; k++) begin
            ins = '0;
            ins.valid = 1'b1;
            ins.bytes = 2'(bt[k]);
            ins.extra = 2'(ex[k]);
            run_instr(ins, clks);
            chk_cnt(clks,
                nc[k] * fcct_pkg::CLKS_PER_MCYCLE);
            chk_val(16'(cycles_o), 16'(nc[k]));
            @(negedge sys_clk_i);
            chk_val(16'(busy_o), 16'h0000);
        end
    endtask

    task automatic test_indirect();
        int clks;
        fcct_pkg::fcct_instr_t ins;
        r0_i = 8'h3C;
        r1_i = 8'hA5;
        for (int s = 0; s < 2; s++) begin
            ins = '0;
            ins.valid = 1'b1;
            ins.bytes = 2'h1;
            ins.uses_ri = 1'b1;
            ins.ri_sel = 1'(s);
            run_instr(ins, clks);
            chk_val(16'(ind_valid_o), 16'h0001);
            chk_val(16'(ext_valid_o), 16'h0000);
            chk_val(16'(ind_addr_o), s ? 16'h00A5 : 16'h003C);
        end
    endtask

    // Default stretch, refused address, then fastest setting
    task automatic test_xmove();
        int clks;
        fcct_pkg::fcct_instr_t ins;
        p2_latch_i = 8'h12;
        r1_i = 8'h5A;
        ins = '0;
        ins.valid = 1'b1;
        ins.bytes = 2'h1;
        ins.xmove = 1'b1;
        ins.uses_ri = 1'b1;
        ins.ri_sel = 1'b1;
        run_instr(ins, clks);
        chk_cnt(clks, 12);
        chk_val(ext_addr_o, 16'h125A);
        chk_val(16'(ext_valid_o), 16'h0001);
        chk_val(16'(ind_valid_o), 16'h0000);
        chk_val(mem_addr, 16'h125A);
        sfr_write(8'h8F, 8'h08);
        chk_val(16'(tctl_o), 16'h0001);
        sfr_write(8'h8E, 8'hF8);
        chk_val(16'(tctl_o), 16'h0008);
        ins.ri_sel = 1'b0;
        r0_i = 8'hC3;
        run_instr(ins, clks);
        chk_cnt(clks, 8);
        chk_val(ext_addr_o, 16'h12C3);
        chk_val(mem_addr, 16'h12C3);
    endtask

    // ************************************************************
    // Verdict and main sequence
    // ************************************************************
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        test_reset();
        test_phase();
        test_timer(fcct_pkg::TMR_SLOW_CLKS);
        test_cycles();
        test_indirect();
        test_xmove();
        test_timer(fcct_pkg::TMR_FAST_CLKS);
        final_report();
    end
endmodule
